//--- design/ipcs_pkg.sv
`default_nettype none

package ipcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration space layout
  localparam int unsigned CFG_ADDR_W = 8;
  localparam logic [CFG_ADDR_W-1:0] CFG_CMD_STS_ADDR = 8'h04;
  localparam int unsigned CFG_WORD_LSB = 2;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned BE_CMD_LO = 0;
  localparam int unsigned BE_CMD_HI = 1;
  localparam int unsigned BE_STS_LO = 2;
  localparam int unsigned BE_STS_HI = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Command register fields
  localparam int unsigned CMD_IO_DECODE_BIT = 0;
  localparam int unsigned CMD_BUS_MASTER_BIT = 2;
  localparam int unsigned CMD_WRITE_INV_BIT = 4;
  localparam int unsigned CMD_PARITY_EN_BIT = 6;
  localparam int unsigned CMD_SYS_ERR_EN_BIT = 8;
  localparam logic [15:0] CMD_WRITABLE_MASK = 16'h0155;
  localparam logic [15:0] CMD_RESET_VAL = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Status register fields
  localparam int unsigned STS_PARITY_ERR_BIT = 15;
  localparam int unsigned STS_SYS_ERR_BIT = 14;
  localparam int unsigned STS_MST_ABORT_BIT = 13;
  localparam int unsigned STS_TGT_ABORT_RX_BIT = 12;
  localparam int unsigned STS_TGT_ABORT_TX_BIT = 11;
  localparam int unsigned STS_MST_PERR_BIT = 8;
  localparam logic [1:0] STS_SELECT_TIMING = 2'h1;
  localparam int unsigned STS_SELECT_TIMING_LSB = 9;
  localparam int unsigned STS_BACK_TO_BACK_BIT = 7;
  localparam logic [15:0] STS_RESET_VAL = 16'h0280;

  // Sticky flag order inside the flag bank
  localparam int unsigned FLAG_N = 6;
  localparam int unsigned FL_PAR_ERR = 0;
  localparam int unsigned FL_SYS_ERR = 1;
  localparam int unsigned FL_MST_ABORT = 2;
  localparam int unsigned FL_TGT_ABORT_RX = 3;
  localparam int unsigned FL_TGT_ABORT_TX = 4;
  localparam int unsigned FL_MST_PERR = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [CFG_ADDR_W-1:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } ipcs_cfg_req_t;

  typedef struct packed {
    logic tgt_wr_perr;
    logic tgt_claimed;
    logic addr_perr;
    logic mst_active;
    logic mst_rd_perr;
    logic mst_tgt_perr;
    logic mst_abort;
    logic mst_tgt_abort;
    logic tgt_abort_sent;
    logic bm_start_wr;
  } ipcs_evt_t;

endpackage : ipcs_pkg

`default_nettype wire

//--- design/ipcs_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none

module ipcs_flag_bank #(
  parameter int unsigned N = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Set and clear requests
  input wire logic [N-1:0] set_i,
  input wire logic [N-1:0] clr_i,
  // Flags
  output logic [N-1:0] flags_o
);

  typedef struct packed {
    logic [N-1:0] flags;
  } ipcs_flag_st_t;

  ipcs_flag_st_t st_q;
  ipcs_flag_st_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Set wins over a clear in the same cycle
  always_comb begin
    st_d = st_q;
    st_d.flags = (st_q.flags & ~clr_i) | set_i; // [RULE9]
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= '0; // [RULE19]
    end else begin
      st_q <= st_d;
    end
  end

  assign flags_o = st_q.flags;

  AST_FLAG_SET_WINS: assert property (@(posedge clk_i) disable iff (srst_i)
    (set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i))) // [RULE9]
    else $error("Flag set lost against clear");

endmodule : ipcs_flag_bank

`default_nettype wire

//--- design/ipcs_cmd_status.sv
// Overview of operation
// RULE1 - Command bits 15:9, 7, 5, 3, 1 read zero, writes ignored.
// RULE2 - Command resets to zero; IDE ports stay dark until programmed.
// RULE3 - System error driven only for address parity, needs bits 8 and 6.
// RULE4 - With bit 6 set, drive parity error for target writes, master reads.
// RULE5 - Write parity errors reported only for cycles this device claimed.
// RULE6 - Bit 4 allows write-and-invalidate; otherwise plain memory write only.
// RULE7 - Bit 2 gates master cycles; set by write or bus-master start.
// RULE8 - Bit 0 enables port decode, only for ports enabled elsewhere.
// RULE9 - Status reads current; writing one clears, zero does nothing.
// RULE10 - Bit 15 set on any detected parity error, ignoring enable.
// RULE11 - Bit 14 set whenever the system error pin is driven low.
// RULE12 - Bit 13 set when own master memory cycle master-aborts.
// RULE13 - Bit 12 set when own master cycle gets target abort.
// RULE14 - Bit 11 set when this target ends a cycle with target abort.
// RULE15 - Select timing field fixed at 01, writes ignored.
// RULE16 - Bit 8 set on master parity error while bit 6 set.
// RULE17 - Bit 7 always reads one: back-to-back capable.
// RULE18 - Status bits 6:0 read zero; status resets to 0280h.
// RULE19 - Reset clears all sticky status flags.
`timescale 1ns/1ps
`default_nettype none

module ipcs_cmd_status
  import ipcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Configuration access
  input wire ipcs_cfg_req_t cfg_req_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  // Bus events from the PCI engine
  input wire ipcs_evt_t evt_i,
  // Port enables from the IDE control register
  input wire logic prim_port_en_i,
  input wire logic sec_port_en_i,
  // Master engine requests
  input wire logic mst_req_i,
  input wire logic mst_want_mwi_i,
  // Decode and master controls
  output logic io_decode_enable_o,
  output logic prim_decode_en_o,
  output logic sec_decode_en_o,
  output logic bus_master_enable_o,
  output logic write_invalidate_enable_o,
  output logic mst_go_o,
  output logic mst_use_mwi_o,
  // Parity error pin
  output logic perr_n_o,
  output logic perr_oe_n_o,
  // System error pin, open drain
  output logic system_error_report_enable_n_o,
  output logic system_error_report_enable_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [15:0] cmd;
    logic perr_drv;
    logic system_error_report_enable_drv;
    logic ack;
    logic [31:0] rdata;
  } ipcs_main_st_t;

  ipcs_main_st_t st_q;
  ipcs_main_st_t st_d;

  logic [FLAG_N-1:0] flag_set;
  logic [FLAG_N-1:0] flag_clr;
  logic [FLAG_N-1:0] flags;
  logic hit;
  logic wr_hit;
  logic [15:0] cmd_mask;
  logic [15:0] sts_mask;
  logic [15:0] sts_clr_bits;
  logic [15:0] sts_view;
  logic par_en;
  logic system_error_report_enable_en;
  logic claimed_wr_perr;

  // Byte enables of one half-word widened to a bit mask
  function automatic logic [15:0] half_mask(input logic lo, input logic hi);
    half_mask = {{BYTE_W{hi}}, {BYTE_W{lo}}};
  endfunction : half_mask

  // Status view built from sticky flags and fixed fields
  function automatic logic [15:0] status_word(input logic [FLAG_N-1:0] f);
    logic [15:0] s;
    s = '0; // [RULE18]
    s[STS_SELECT_TIMING_LSB +: 2] = STS_SELECT_TIMING; // [RULE15]
    s[STS_BACK_TO_BACK_BIT] = 1'b1; // [RULE17]
    s[STS_PARITY_ERR_BIT] = f[FL_PAR_ERR];
    s[STS_SYS_ERR_BIT] = f[FL_SYS_ERR];
    s[STS_MST_ABORT_BIT] = f[FL_MST_ABORT];
    s[STS_TGT_ABORT_RX_BIT] = f[FL_TGT_ABORT_RX];
    s[STS_TGT_ABORT_TX_BIT] = f[FL_TGT_ABORT_TX];
    s[STS_MST_PERR_BIT] = f[FL_MST_PERR];
    status_word = s;
  endfunction : status_word

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign hit = cfg_req_i.valid &&
    (cfg_req_i.addr[CFG_ADDR_W-1:CFG_WORD_LSB] ==
     CFG_CMD_STS_ADDR[CFG_ADDR_W-1:CFG_WORD_LSB]);
  assign wr_hit = hit && cfg_req_i.write;
  assign cmd_mask = half_mask(cfg_req_i.be[BE_CMD_LO], cfg_req_i.be[BE_CMD_HI]);
  assign sts_mask = half_mask(cfg_req_i.be[BE_STS_LO], cfg_req_i.be[BE_STS_HI]);
  assign par_en = st_q.cmd[CMD_PARITY_EN_BIT];
  assign system_error_report_enable_en = st_q.cmd[CMD_SYS_ERR_EN_BIT];
  assign claimed_wr_perr = evt_i.tgt_wr_perr && evt_i.tgt_claimed; // [RULE5]
  assign sts_view = status_word(flags);

  ////////////////////////////////////////////////////////////////////////////
  // Status flag sources and write-one clears
  always_comb begin
    flag_set = '0;
    flag_set[FL_PAR_ERR] = claimed_wr_perr || evt_i.addr_perr ||
      (evt_i.mst_active && evt_i.mst_rd_perr); // [RULE10]
    flag_set[FL_SYS_ERR] = st_q.system_error_report_enable_drv; // [RULE11]
    flag_set[FL_MST_ABORT] = evt_i.mst_active && evt_i.mst_abort; // [RULE12]
    flag_set[FL_TGT_ABORT_RX] = evt_i.mst_active &&
      evt_i.mst_tgt_abort; // [RULE13]
    flag_set[FL_TGT_ABORT_TX] = evt_i.tgt_abort_sent; // [RULE14]
    flag_set[FL_MST_PERR] = par_en && evt_i.mst_active &&
      (evt_i.mst_rd_perr || evt_i.mst_tgt_perr); // [RULE16]
  end

  assign sts_clr_bits = wr_hit ? (cfg_req_i.wdata[31:16] & sts_mask) : '0;

  always_comb begin
    flag_clr = '0;
    flag_clr[FL_PAR_ERR] = sts_clr_bits[STS_PARITY_ERR_BIT]; // [RULE9]
    flag_clr[FL_SYS_ERR] = sts_clr_bits[STS_SYS_ERR_BIT];
    flag_clr[FL_MST_ABORT] = sts_clr_bits[STS_MST_ABORT_BIT];
    flag_clr[FL_TGT_ABORT_RX] = sts_clr_bits[STS_TGT_ABORT_RX_BIT];
    flag_clr[FL_TGT_ABORT_TX] = sts_clr_bits[STS_TGT_ABORT_TX_BIT];
    flag_clr[FL_MST_PERR] = sts_clr_bits[STS_MST_PERR_BIT];
  end

  ipcs_flag_bank #(
    .N(FLAG_N)
  ) u_flags (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .set_i(flag_set),
    .clr_i(flag_clr),
    .flags_o(flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    if (wr_hit) begin
      // Only implemented bits take write data
      st_d.cmd = (st_q.cmd & ~(cmd_mask & CMD_WRITABLE_MASK)) |
        (cfg_req_i.wdata[15:0] & cmd_mask & CMD_WRITABLE_MASK); // [RULE1]
    end
    if (evt_i.bm_start_wr) begin
      st_d.cmd[CMD_BUS_MASTER_BIT] = 1'b1; // [RULE7]
    end
    // Pins drive one cycle after the detected error
    st_d.perr_drv = par_en &&
      (claimed_wr_perr || (evt_i.mst_active && evt_i.mst_rd_perr)); // [RULE4]
    st_d.system_error_report_enable_drv = system_error_report_enable_en && par_en && evt_i.addr_perr; // [RULE3]
    st_d.ack = cfg_req_i.valid;
    if (cfg_req_i.valid && !cfg_req_i.write) begin
      // Unmapped config words read as zero
      st_d.rdata = hit ? {sts_view, st_q.cmd} : '0; // [RULE9]
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q.cmd <= CMD_RESET_VAL; // [RULE2]
      st_q.perr_drv <= 1'b0;
      st_q.system_error_report_enable_drv <= 1'b0;
      st_q.ack <= 1'b0;
      st_q.rdata <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cfg_ack_o = st_q.ack;
  assign cfg_rdata_o = st_q.rdata;
  assign io_decode_enable_o = st_q.cmd[CMD_IO_DECODE_BIT];
  // Address ranges and base registers live in the port decoder
  assign prim_decode_en_o = io_decode_enable_o && prim_port_en_i; // [RULE8]
  assign sec_decode_en_o = io_decode_enable_o && sec_port_en_i; // [RULE8]
  assign bus_master_enable_o = st_q.cmd[CMD_BUS_MASTER_BIT];
  assign write_invalidate_enable_o = st_q.cmd[CMD_WRITE_INV_BIT];
  assign mst_go_o = mst_req_i && bus_master_enable_o; // [RULE7]
  assign mst_use_mwi_o = mst_want_mwi_i && write_invalidate_enable_o; // [RULE6]
  assign perr_n_o = ~st_q.perr_drv;
  assign perr_oe_n_o = ~st_q.perr_drv;
  // Open drain: only ever pulls low
  assign system_error_report_enable_n_o = ~st_q.system_error_report_enable_drv;
  assign system_error_report_enable_oe_n_o = ~st_q.system_error_report_enable_drv;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_CMD_RSVD_ZERO: assert property ( // [RULE1]
    (st_q.cmd & ~CMD_WRITABLE_MASK) == '0)
    else $error("Reserved command bit set");

  AST_CMD_RESET: assert property (@(posedge clk_i) disable iff (1'b0) // [RULE2]
    srst_i |=> (st_q.cmd == CMD_RESET_VAL && !io_decode_enable_o))
    else $error("Command not zero after reset");

  AST_SYSTEM_ERROR_REPORT_ENABLE_CAUSE: assert property ( // [RULE3]
    !system_error_report_enable_oe_n_o |-> $past(evt_i.addr_perr && system_error_report_enable_en && par_en))
    else $error("System error driven without cause");

  AST_SYSTEM_ERROR_REPORT_ENABLE_FIRE: assert property ( // [RULE3]
    (evt_i.addr_perr && system_error_report_enable_en && par_en) |=> !system_error_report_enable_n_o)
    else $error("System error not driven");

  AST_PERR_FIRE: assert property ( // [RULE4]
    (par_en && claimed_wr_perr) |=> (!perr_n_o && !perr_oe_n_o))
    else $error("Parity error not driven");

  AST_PERR_CLAIM: assert property ( // [RULE5]
    (evt_i.tgt_wr_perr && !evt_i.tgt_claimed && !evt_i.mst_active)
    |=> perr_oe_n_o)
    else $error("Parity driven for unclaimed write");

  AST_PERR_DISABLED: assert property ( // [RULE4]
    !par_en |=> perr_oe_n_o)
    else $error("Parity driven while disabled");

  AST_MWI_GATE: assert property ( // [RULE6]
    mst_use_mwi_o |-> (st_q.cmd[CMD_WRITE_INV_BIT] && mst_want_mwi_i))
    else $error("Write invalidate used while disabled");

  AST_BM_START: assert property ( // [RULE7]
    evt_i.bm_start_wr |=> bus_master_enable_o)
    else $error("Bus master start did not enable mastering");

  AST_MST_GATE: assert property ( // [RULE7]
    !bus_master_enable_o |-> !mst_go_o)
    else $error("Master cycle without enable");

  AST_DECODE_GATE: assert property ( // [RULE8]
    prim_decode_en_o |-> (io_decode_enable_o && prim_port_en_i))
    else $error("Primary decode without enables");

  AST_W1C: assert property ( // [RULE9]
    (wr_hit && sts_clr_bits[STS_MST_ABORT_BIT] && !flag_set[FL_MST_ABORT])
    |=> !sts_view[STS_MST_ABORT_BIT])
    else $error("Write one did not clear flag");

  AST_PE_ANY: assert property ( // [RULE10]
    evt_i.addr_perr |=> sts_view[STS_PARITY_ERR_BIT])
    else $error("Parity flag not set");

  AST_SE_FLAG: assert property ( // [RULE11]
    !system_error_report_enable_n_o |=> sts_view[STS_SYS_ERR_BIT])
    else $error("System error flag not set");

  AST_ABORTS: assert property ( // [RULE12]
    (evt_i.mst_active && evt_i.mst_abort) ##1 1'b1 |->
    sts_view[STS_MST_ABORT_BIT] && $past(evt_i.mst_active))
    else $error("Master abort flag not set");

  AST_FIXED_BITS: assert property ( // [RULE15]
    sts_view[6:0] == '0 && sts_view[STS_BACK_TO_BACK_BIT] &&
    sts_view[STS_SELECT_TIMING_LSB +: 2] == STS_SELECT_TIMING)
    else $error("Fixed status fields wrong");

  AST_STS_RESET: assert property (@(posedge clk_i) disable iff (1'b0)
    srst_i ##1 !srst_i |-> sts_view == STS_RESET_VAL) // [RULE18]
    else $error("Status not at reset value");

  AST_READ_ACK: assert property (
    (cfg_req_i.valid && !cfg_req_i.write && hit) |=>
    cfg_ack_o && cfg_rdata_o[15:0] == $past(st_q.cmd))
    else $error("Read data or ack wrong");

  AST_PE_TGT_WR: assert property ( // [RULE10]
    claimed_wr_perr |=> sts_view[STS_PARITY_ERR_BIT])
    else $error("Target write parity not flagged");

  AST_PE_NO_ENABLE: assert property ( // [RULE10]
    (!par_en && evt_i.mst_active && evt_i.mst_rd_perr) |=>
    sts_view[STS_PARITY_ERR_BIT])
    else $error("Master read parity not flagged");

  AST_PERR_MASTER: assert property ( // [RULE4]
    (par_en && evt_i.mst_active && evt_i.mst_rd_perr) |=>
    (!perr_n_o && !perr_oe_n_o))
    else $error("Master read parity not driven");

  AST_BM_WRITE: assert property ( // [RULE7]
    (wr_hit && cmd_mask[CMD_BUS_MASTER_BIT] &&
     cfg_req_i.wdata[CMD_BUS_MASTER_BIT]) |=> bus_master_enable_o)
    else $error("Bus master bit not written");

  AST_SEC_DECODE_GATE: assert property ( // [RULE8]
    sec_decode_en_o |-> (io_decode_enable_o && sec_port_en_i))
    else $error("Secondary decode without enables");

  AST_ACK_NEXT: assert property ( // [RULE9]
    cfg_req_i.valid |=> cfg_ack_o)
    else $error("Request not acknowledged");

  AST_RDATA_HOLD: assert property ( // [RULE9]
    !(cfg_req_i.valid && !cfg_req_i.write) |=> $stable(cfg_rdata_o))
    else $error("Read data changed without a read");

  AST_FLAG_STICKY: assert property ( // [RULE9]
    (sts_view[STS_TGT_ABORT_TX_BIT] && !sts_clr_bits[STS_TGT_ABORT_TX_BIT])
    |=> sts_view[STS_TGT_ABORT_TX_BIT])
    else $error("Status flag lost without a clear");

  AST_RTA_FLAG: assert property ( // [RULE13]
    (evt_i.mst_active && evt_i.mst_tgt_abort) |=>
    sts_view[STS_TGT_ABORT_RX_BIT])
    else $error("Target abort received not flagged");

  AST_RTA_IDLE: assert property ( // [RULE13]
    (!evt_i.mst_active && !sts_view[STS_TGT_ABORT_RX_BIT]) |=>
    !sts_view[STS_TGT_ABORT_RX_BIT])
    else $error("Target abort received set while not master");

  AST_TA_FLAG: assert property ( // [RULE14]
    evt_i.tgt_abort_sent |=> sts_view[STS_TGT_ABORT_TX_BIT])
    else $error("Target abort signalled not flagged");

  AST_MPE_FLAG: assert property ( // [RULE16]
    (par_en && evt_i.mst_active && evt_i.mst_tgt_perr) |=>
    sts_view[STS_MST_PERR_BIT])
    else $error("Master parity flag not set");

  AST_MPE_MASK: assert property ( // [RULE16]
    (!par_en && !sts_view[STS_MST_PERR_BIT]) |=> !sts_view[STS_MST_PERR_BIT])
    else $error("Master parity flag set while disabled");

  COV_SYSTEM_ERROR_REPORT_ENABLE: cover property (!system_error_report_enable_n_o);
  COV_PERR_MASTER: cover property (evt_i.mst_active && flag_set[FL_MST_PERR]);
  COV_SET_CLR_SAME: cover property ((flag_set & flag_clr) != '0);
  COV_BM_START: cover property (evt_i.bm_start_wr ##1 mst_go_o);

endmodule : ipcs_cmd_status

`default_nettype wire

//--- tb/ipcs_bus_agent.sv
`timescale 1ns/1ps
`default_nettype none

module ipcs_bus_agent
  import ipcs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Event request from the bench
  input wire logic go_i,
  input wire logic [2:0] kind_i,
  input wire logic claim_i,
  // Bus events toward the block
  output var ipcs_evt_t evt_o
);
  ////////////////////////////////////////////////////////////////////////////
  // One event per request, one cycle long; master kinds also flag mastership
  always_ff @(posedge clk_i) begin
    evt_o <= '0;
    if (!srst_i && go_i) begin
      case (kind_i)
        3'h0: begin // Claim only when our decode hit
          evt_o.tgt_wr_perr <= 1'b1;
          evt_o.tgt_claimed <= claim_i;
        end
        3'h1: evt_o.addr_perr <= 1'b1;
        3'h2: evt_o.mst_rd_perr <= 1'b1;
        3'h3: evt_o.mst_tgt_perr <= 1'b1;
        3'h4: evt_o.mst_abort <= 1'b1;
        3'h5: evt_o.mst_tgt_abort <= 1'b1;
        3'h6: evt_o.tgt_abort_sent <= 1'b1;
        default: evt_o.bm_start_wr <= 1'b1;
      endcase
      // Mastership is a one-cycle pulse in the same cycle as the master events
      evt_o.mst_active <= kind_i inside {3'h2, 3'h3, 3'h4, 3'h5};
    end
  end
endmodule : ipcs_bus_agent

`default_nettype wire

//--- tb/ipcs_cmd_status_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ipcs_cmd_status_tb
  import ipcs_pkg::*;
;
  logic clk_i, srst_i, go, claim, ack, prim_en, sec_en, mreq, mwi;
  logic io_en, pdec, sdec, bme, wie, mgo, mmwi;
  logic perr_n, perr_oe_n, system_error_report_enable_n, system_error_report_enable_oe_n;
  logic [2:0] kind;
  logic [31:0] rdata;
  logic [15:0] cmd_m;
  logic [19:0] ev;
  ipcs_cfg_req_t req;
  ipcs_evt_t evt;
  int n_mismatch, check_count, cyc;

  ipcs_bus_agent i_ipcs_bus_agent (.clk_i(clk_i), .srst_i(srst_i),
    .go_i(go), .kind_i(kind), .claim_i(claim), .evt_o(evt));

  ipcs_cmd_status i_ipcs_cmd_status (.clk_i(clk_i), .srst_i(srst_i),
    .cfg_req_i(req), .cfg_ack_o(ack), .cfg_rdata_o(rdata), .evt_i(evt),
    .prim_port_en_i(prim_en), .sec_port_en_i(sec_en), .mst_req_i(mreq),
    .mst_want_mwi_i(mwi), .io_decode_enable_o(io_en),
    .prim_decode_en_o(pdec), .sec_decode_en_o(sdec),
    .bus_master_enable_o(bme), .write_invalidate_enable_o(wie),
    .mst_go_o(mgo), .mst_use_mwi_o(mmwi), .perr_n_o(perr_n),
    .perr_oe_n_o(perr_oe_n), .system_error_report_enable_n_o(system_error_report_enable_n), .system_error_report_enable_oe_n_o(system_error_report_enable_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Ceiling far above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_pins(input logic [3:0] g, input logic [3:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t pins got=%h exp=%h", $time, g, e);
    end
  endtask : chk_pins

  task automatic chk_ctl(input logic [6:0] g, input logic [6:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t ctl got=%h exp=%h", $time, g, e);
    end
  endtask : chk_ctl

  function automatic logic [6:0] exp_ctl();
    return {cmd_m[0], cmd_m[0] & prim_en, cmd_m[0] & sec_en, cmd_m[2],
      cmd_m[4], mreq & cmd_m[2], mwi & cmd_m[4]};
  endfunction : exp_ctl

  // Status bits set and pin levels {perr_n, perr_oe_n, system_error_report_enable_n, system_error_report_enable_oe_n}
  function automatic logic [19:0] exp_ev(input logic [2:0] k,
      input logic c, input logic [15:0] cm);
    logic [15:0] f;
    logic [3:0] p;
    f = '0;
    p = 4'hF;
    case (k)
      3'h0: begin
        f[15] = c;
        if (c && cm[6]) p[3:2] = 2'b00;
      end
      3'h1: begin
        f[15] = 1'b1;
        if (cm[6] && cm[8]) {p[1:0], f[14]} = 3'b001;
      end
      3'h2: begin
        f[15] = 1'b1;
        if (cm[6]) {p[3:2], f[8]} = 3'b001;
      end
      3'h3: f[8] = cm[6];
      3'h4: f[13] = 1'b1;
      3'h5: f[12] = 1'b1;
      3'h6: f[11] = 1'b1;
      default: f = '0;
    endcase
    return {f, p};
  endfunction : exp_ev

  // One access, then one idle edge so back-to-back calls never glitch valid
  task automatic cfg(input logic w, input logic [7:0] a,
      input logic [3:0] be, input logic [31:0] d);
    logic [15:0] bm;
    bm = {{8{be[1]}}, {8{be[0]}}} & 16'h0155;
    req = '{1'b1, w, a, be, d};
    @(posedge clk_i);
    #1;
    req.valid = 1'b0;
    if (w && a[7:2] == 6'h01) cmd_m = (cmd_m & ~bm) | (d[15:0] & bm);
    chk_ctl({6'h00, ack}, 7'h01);
    @(posedge clk_i);
    #1;
    chk_ctl({6'h00, ack}, 7'h00);
  endtask : cfg

  task automatic fire(input logic [2:0] k);
    kind = k;
    claim = 1'($urandom);
    go = 1'b1;
    @(posedge clk_i);
    #1;
    go = 1'b0;
    ev = exp_ev(k, claim, cmd_m);
    @(posedge clk_i);
    #1;
    chk_pins({perr_n, perr_oe_n, system_error_report_enable_n, system_error_report_enable_oe_n}, ev[3:0]);
    @(posedge clk_i);
    #1;
    chk_pins({perr_n, perr_oe_n, system_error_report_enable_n, system_error_report_enable_oe_n}, 4'hF);
    if (k == 3'h7) cmd_m[2] = 1'b1; // Start bit write
  endtask : fire

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] tab [4];
    tab = '{16'h0000, 16'h0040, 16'h0140, 16'h0100};
    {srst_i, go, kind, claim, req} = {1'b1, 5'h00, 46'h0};
    {prim_en, sec_en, mreq, mwi, cmd_m} = 20'h0;
    void'($urandom(26811));
    repeat (12) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    cfg(1'b0, 8'h04, 4'hF, 32'h0);
    chk_word(rdata, 32'h0280_0000);
    $display("test reset done");
    cfg(1'b1, 8'h04, 4'hF, 32'hFFFF_FFFF);
    for (int i = 0; i < 13; i++) begin
      {prim_en, sec_en, mreq, mwi} = 4'($urandom);
      cfg(1'b0, 8'h04, 4'hF, $urandom);
      chk_word(rdata, {16'h0280, cmd_m});
      chk_ctl({io_en, pdec, sdec, bme, wie, mgo, mmwi}, exp_ctl());
      cfg(1'b1, 8'h04 | 8'($urandom_range(0, 3)), 4'($urandom), $urandom);
    end
    $display("test command lanes done");
    cfg(1'b1, 8'($urandom_range(8, 255)), 4'hF, 32'hFFFF_FFFF);
    cfg(1'b0, 8'($urandom_range(8, 255)), 4'hF, 32'h0);
    chk_word(rdata, 32'h0); // Unmapped reads zero
    cfg(1'b0, 8'h04, 4'hF, 32'h0);
    chk_word(rdata, {16'h0280, cmd_m});
    $display("test unmapped done");
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 8; k++) begin
        cfg(1'b1, 8'h04, 4'h3, {16'h0, tab[i]}); // Program first
        fire(3'(k));
        cfg(1'b1, 8'h04, 4'hC, 32'h0);
        cfg(1'b0, 8'h04, 4'hF, $urandom);
        chk_word(rdata, {16'h0280 | ev[19:4], cmd_m});
        cfg(1'b1, 8'h04, 4'hC, 32'hFFFF_0000); // Clear flags
        cfg(1'b0, 8'h04, 4'hF, $urandom);
        chk_word(rdata, {16'h0280, cmd_m});
      end
    end
    $display("test events done");
    // Corner: clear and target abort taken on one edge, the set must win
    kind = 3'h6;
    go = 1'b1;
    @(posedge clk_i);
    #1;
    go = 1'b0;
    req = '{1'b1, 1'b1, 8'h04, 4'hC, 32'hFFFF_0000};
    @(posedge clk_i);
    #1;
    req.valid = 1'b0;
    @(posedge clk_i);
    #1;
    cfg(1'b0, 8'h04, 4'hF, 32'h0);
    chk_word(rdata, {16'h0A80, cmd_m});
    $display("test set wins done");
    cfg(1'b1, 8'h04, 4'h3, 32'h0000_0155);
    fire(3'h4);
    srst_i = 1'b1;
    @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    cmd_m = 16'h0000;
    cfg(1'b0, 8'h04, 4'hF, 32'h0);
    chk_word(rdata, 32'h0280_0000);
    chk_ctl({io_en, pdec, sdec, bme, wie, mgo, mmwi}, exp_ctl());
    $display("test second reset done");
    complete_run();
  end
endmodule : ipcs_cmd_status_tb

`default_nettype wire
